/* design/dtc_top.sv */
// Debug trace control: control and FIFO extension registers, arm and capture gating, break requests.
// Assumes APB master on clk, synchronous inputs, trigger/FIFO/comparator logic kept outside.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module dtc_top #(
  parameter int AW = dtc_pkg::CADDR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dtc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic secure,
  input wire logic soft_reset,
  input wire logic trig_begin,
  input wire logic [3:0] trig_mode,
  input wire logic trig_hit,
  input wire logic fifo_full,
  input wire logic cof_valid,
  input wire logic cof_paged,
  input wire logic [dtc_pkg::PAGE_W-1:0] cof_ppage,
  input wire logic [AW-1:0] cof_addr,
  input wire logic [AW-1:0] comp_c_addr,
  input wire logic comp_c_page,
  input wire logic comp_c_match,
  input wire logic head_adv,
  input wire logic head_page,
  input wire logic head_b16,
  output logic module_enable_bit,
  output logic armed,
  output logic break_req,
  output logic break_tag,
  output logic fifo_store,
  output logic [AW-1:0] fifo_word,
  output logic fifo_page,
  output logic comp_c_load,
  output logic [AW-1:0] comp_c_load_addr,
  output logic comp_c_load_page
);
  typedef struct packed {
    logic en;
    logic arm;
    logic tag;
    logic brk;
    logic loop;
    logic fx_page;
    logic fx_b16;
    logic storing;
    logic run_done;
    logic brk_req;
    logic brk_tag;
    logic store;
    logic [AW-1:0] word;
    logic page;
    logic load;
    logic [31:0] rdata;
  } dtc_state_t;

  localparam dtc_state_t ST_RESET = '{
    en: dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_EN_BIT],
    arm: dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_ARM_BIT],
    tag: dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_TAG_BIT],
    brk: dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_BRK_BIT],
    loop: dtc_pkg::CTRL_RESET[dtc_pkg::CTRL_LOOP_BIT],
    fx_page: dtc_pkg::FX_RESET[dtc_pkg::FX_PAGE_BIT],
    fx_b16: dtc_pkg::FX_RESET[dtc_pkg::FX_B16_BIT],
    default: '0
  };

  dtc_state_t st_r;
  dtc_state_t st_nxt;
  logic event_only;
  logic capture_ok;
  logic run_end;
  logic end_run_kind;
  logic cap_store;
  logic cap_load;
  logic [AW-1:0] cap_word;
  logic cap_page;
  logic wr_ctrl;

  function automatic logic is_mapped(input logic [dtc_pkg::ADDR_W-1:0] a);
    is_mapped = (a == dtc_pkg::ADDR_CTRL) || (a == dtc_pkg::ADDR_FIFO_EXT);
  endfunction

  function automatic logic [7:0] ctrl_image(input dtc_state_t s);
    ctrl_image = 8'h00;
    ctrl_image[dtc_pkg::CTRL_EN_BIT] = s.en;
    ctrl_image[dtc_pkg::CTRL_ARM_BIT] = s.arm;
    ctrl_image[dtc_pkg::CTRL_TAG_BIT] = s.tag;
    ctrl_image[dtc_pkg::CTRL_BRK_BIT] = s.brk;
    ctrl_image[dtc_pkg::CTRL_LOOP_BIT] = s.loop;
  endfunction

  assign event_only = (trig_mode == dtc_pkg::TRG_EVONLY_B) || (trig_mode == dtc_pkg::TRG_A_THEN_EVONLY_B);
  // Begin-trigger stores only after the trigger; end-trigger stores from arming
  assign capture_ok = st_r.en & st_r.arm & (trig_begin ? st_r.storing : 1'b1);
  assign run_end = st_r.en & st_r.arm & (trig_begin ? (st_r.storing & fifo_full) : trig_hit);
  assign end_run_kind = st_r.run_done & st_r.en & ~trig_begin;
  assign wr_ctrl = psel & penable & pwrite & (paddr == dtc_pkg::ADDR_CTRL);

  dtc_capture #(
    .AW(AW)
  ) u_capture (
    .clk(clk),
    .rst(rst),
    .capture_ok(capture_ok),
    .cof_valid(cof_valid),
    .loop_sel(st_r.loop),
    .event_only(event_only),
    .cof_paged(cof_paged),
    .cof_ppage(cof_ppage),
    .cof_addr(cof_addr),
    .comp_c_addr(comp_c_addr),
    .comp_c_page(comp_c_page),
    .do_store(cap_store),
    .do_load(cap_load),
    .word(cap_word),
    .word_page(cap_page)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.brk_req = 1'b0;
    st_nxt.brk_tag = 1'b0;
    st_nxt.store = 1'b0;
    st_nxt.load = 1'b0;
    // Read data is captured in the setup cycle so it comes from a flop at access
    if (psel && !penable) begin
      st_nxt.rdata = 32'h0000_0000;
      if (paddr == dtc_pkg::ADDR_CTRL) begin
        st_nxt.rdata[7:0] = ctrl_image(st_r);
      end else if (paddr == dtc_pkg::ADDR_FIFO_EXT) begin
        st_nxt.rdata[dtc_pkg::FX_PAGE_BIT] = st_r.fx_page;
        st_nxt.rdata[dtc_pkg::FX_B16_BIT] = st_r.fx_b16;
      end
    end
    // Extension register writes fall through: read-only
    if (wr_ctrl) begin
      st_nxt.en = pwdata[dtc_pkg::CTRL_EN_BIT];
      st_nxt.arm = pwdata[dtc_pkg::CTRL_ARM_BIT];
      st_nxt.tag = pwdata[dtc_pkg::CTRL_TAG_BIT];
      st_nxt.brk = pwdata[dtc_pkg::CTRL_BRK_BIT];
      st_nxt.loop = pwdata[dtc_pkg::CTRL_LOOP_BIT];
      if (!pwdata[dtc_pkg::CTRL_ARM_BIT]) begin
        st_nxt.storing = 1'b0;
      end
    end
    if (st_r.en && st_r.arm && trig_begin && trig_hit) begin
      st_nxt.storing = 1'b1;
    end
    // Hardware end of run wins over a simultaneous software write
    if (run_end) begin
      st_nxt.arm = 1'b0;
      st_nxt.storing = 1'b0;
      st_nxt.run_done = 1'b1;
    end
    if (st_r.en && st_r.brk && (run_end || comp_c_match)) begin
      st_nxt.brk_req = 1'b1;
      st_nxt.brk_tag = st_r.tag;
    end
    if (cap_store) begin
      st_nxt.store = 1'b1;
      st_nxt.word = cap_word;
      st_nxt.page = cap_page;
    end
    if (cap_load) begin
      st_nxt.load = 1'b1;
    end
    if (head_adv) begin
      st_nxt.fx_page = head_page;
      st_nxt.fx_b16 = head_b16;
    end
    if (secure) begin
      st_nxt.en = 1'b0;
    end
    // Non-power-on reset: end-run kind keeps most state
    if (soft_reset) begin
      if (end_run_kind) begin
        st_nxt.arm = 1'b0;
        st_nxt.brk = 1'b0;
        st_nxt.storing = 1'b0;
        st_nxt.run_done = 1'b0;
        st_nxt.brk_req = 1'b0;
        st_nxt.brk_tag = 1'b0;
        st_nxt.store = 1'b0;
        st_nxt.load = 1'b0;
        st_nxt.en = st_r.en & ~secure;
        // Reset outranks a control write landing in the same cycle
        st_nxt.tag = st_r.tag;
        st_nxt.loop = st_r.loop;
        st_nxt.fx_page = st_r.fx_page;
        st_nxt.fx_b16 = st_r.fx_b16;
      end else begin
        st_nxt = ST_RESET;
        st_nxt.en = ST_RESET.en & ~secure;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign module_enable_bit = st_r.en;
  assign armed = st_r.arm;
  assign break_req = st_r.brk_req;
  assign break_tag = st_r.brk_tag;
  assign fifo_store = st_r.store;
  assign fifo_word = st_r.word;
  assign fifo_page = st_r.page;
  assign comp_c_load = st_r.load;
  assign comp_c_load_addr = st_r.word;
  assign comp_c_load_page = st_r.page;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_end_reset;
    soft_reset && end_run_kind;
  endsequence

  property p_secure_enable;
    secure |=> !module_enable_bit;
  endproperty
  a_secure_enable: assert property (p_secure_enable) else $error("enable set while secure");

  property p_idle_no_store;
    !armed |=> !fifo_store;
  endproperty
  a_idle_no_store: assert property (p_idle_no_store) else $error("store while not armed");

  property p_tag_follows;
    break_req |-> break_tag == $past(st_r.tag);
  endproperty
  a_tag_follows: assert property (p_tag_follows) else $error("break kind wrong");

  property p_no_break_disabled;
    (!st_r.brk && !soft_reset) |=> !break_req && !break_tag;
  endproperty
  a_no_break_disabled: assert property (p_no_break_disabled) else $error("break without enable");

  property p_match_break;
    (comp_c_match && st_r.brk && module_enable_bit && !soft_reset) |=> break_req;
  endproperty
  a_match_break: assert property (p_match_break) else $error("match break missing");

  property p_end_reset_ctrl;
    s_end_reset |=> !armed && !st_r.brk && st_r.tag == $past(st_r.tag) && st_r.loop == $past(st_r.loop);
  endproperty
  a_end_reset_ctrl: assert property (p_end_reset_ctrl) else $error("end-run reset control wrong");

  property p_end_reset_fx;
    s_end_reset |=> $stable(st_r.fx_page) && $stable(st_r.fx_b16);
  endproperty
  a_end_reset_fx: assert property (p_end_reset_fx) else $error("extension lost on end-run reset");

  property p_fx_update;
    (head_adv && !soft_reset) |=> st_r.fx_b16 == $past(head_b16) && st_r.fx_page == $past(head_page);
  endproperty
  a_fx_update: assert property (p_fx_update) else $error("extension not updated");

  property p_fx_read;
    (psel && !penable && paddr == dtc_pkg::ADDR_FIFO_EXT) |=> prdata[6:1] == 6'h00 && prdata[31:8] == 24'h000000;
  endproperty
  a_fx_read: assert property (p_fx_read) else $error("reserved bits nonzero");

  property p_begin_waits;
    (armed && trig_begin && !st_r.storing) |-> !cap_store;
  endproperty
  a_begin_waits: assert property (p_begin_waits) else $error("stored before begin trigger");

  property p_paged_word;
    (cap_store && cof_paged && !event_only && !soft_reset) |=>
      fifo_page && fifo_word[AW-1 -: dtc_pkg::PAGE_W] == $past(cof_ppage);
  endproperty
  a_paged_word: assert property (p_paged_word) else $error("paged word layout wrong");
endmodule

/* pkg/dtc_pkg.sv */
// Constants for the debug trace control block: register map, control bits, reset values.
// Assumes a 32-bit APB slave where each register index maps to byte address index*4.
package dtc_pkg;
  localparam int ADDR_W = 8;
  localparam int CADDR_W = 17;
  // Register indices as printed; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_FIFO_EXT = 8'h0B;
  localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_FIFO_EXT = 8'h2C;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h30;
  // Control field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_ARM_BIT = 6;
  localparam int CTRL_TAG_BIT = 5;
  localparam int CTRL_BRK_BIT = 4;
  localparam int CTRL_LOOP_BIT = 0;
  // FIFO extension field positions
  localparam int FX_PAGE_BIT = 7;
  localparam int FX_B16_BIT = 0;
  // Power-on values
  localparam logic [7:0] CTRL_RESET = 8'hC0;
  localparam logic [7:0] FX_RESET = 8'h00;
  // Paged word layout: page bits on top of the low CPU address bits
  localparam int PAGE_W = 3;
  localparam int LOW_ADDR_W = 14;
  // Event-only trigger mode codes
  localparam logic [3:0] TRG_EVONLY_B = 4'h3;
  localparam logic [3:0] TRG_A_THEN_EVONLY_B = 4'h4;
endpackage

/* design/dtc_capture.sv */
// Capture qualifier: builds the FIFO word and applies loop suppression against comparator C.
// Assumes comparator C value and page qualifier come from outside; logic is combinational.
`timescale 1ns/1ps
module dtc_capture #(
  parameter int AW = dtc_pkg::CADDR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic capture_ok,
  input wire logic cof_valid,
  input wire logic loop_sel,
  input wire logic event_only,
  input wire logic cof_paged,
  input wire logic [dtc_pkg::PAGE_W-1:0] cof_ppage,
  input wire logic [AW-1:0] cof_addr,
  input wire logic [AW-1:0] comp_c_addr,
  input wire logic comp_c_page,
  output logic do_store,
  output logic do_load,
  output logic [AW-1:0] word,
  output logic word_page
);
  logic loop_on;
  logic hit;

  always_comb begin
    // Paged words carry page bits above the low CPU address bits
    if (cof_paged && !event_only) begin
      word = {cof_ppage, cof_addr[dtc_pkg::LOW_ADDR_W-1:0]};
    end else begin
      word = cof_addr;
    end
    word_page = cof_paged & ~event_only;
    loop_on = loop_sel & ~event_only;
    hit = (word == comp_c_addr) && (word_page == comp_c_page);
    do_store = capture_ok & cof_valid & ~(loop_on & hit);
    do_load = capture_ok & cof_valid & loop_on & ~hit;
  end

  property p_loop_skip;
    @(posedge clk) disable iff (rst)
      (loop_sel && !event_only && hit) |-> !do_store && !do_load;
  endproperty
  a_loop_skip: assert property (p_loop_skip) else $error("loop match still stored");

  property p_load_with_store;
    @(posedge clk) disable iff (rst)
      do_load |-> do_store && !hit;
  endproperty
  a_load_with_store: assert property (p_load_with_store) else $error("comparator load without store");

  property p_event_page;
    @(posedge clk) disable iff (rst)
      event_only |-> !word_page && !do_load;
  endproperty
  a_event_page: assert property (p_event_page) else $error("event-only word flagged paged");
endmodule

/* bench/dtc_cpu_model.sv */
// Far-side model: CPU break sink and comparator C storage.
// Assumes one clock and one-cycle load and break strobes from the block.
`timescale 1ns/1ps
module dtc_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic break_req,
  input wire logic break_tag,
  input wire logic comp_c_load,
  input wire logic [16:0] comp_c_load_addr,
  input wire logic comp_c_load_page,
  output logic [16:0] comp_c_addr,
  output logic comp_c_page,
  output logic [7:0] tag_cnt,
  output logic [7:0] force_cnt
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Start away from any address the bench offers
      comp_c_addr <= 17'h1FFFF;
      comp_c_page <= 1'h1;
      tag_cnt <= 8'h00;
      force_cnt <= 8'h00;
    end else begin
      if (comp_c_load) begin
        comp_c_addr <= comp_c_load_addr;
        comp_c_page <= comp_c_load_page;
      end
      if (break_req && break_tag) tag_cnt <= tag_cnt + 8'h01;
      if (break_req && !break_tag) force_cnt <= force_cnt + 8'h01;
    end
  end
endmodule

/* bench/debug_trace_control_tb.sv */
// Testbench for the debug trace control block: registers, capture, loop mode, breaks, end-run reset.
// Assumes dtc_top on APB byte addresses and the CPU model holding comparator C.
`timescale 1ns/1ps
module debug_trace_control_tb;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, errv, secure = 1'h0, soft_reset = 1'h0, trig_begin = 1'h0, trig_hit = 1'h0;
  logic fifo_full = 1'h0, cof_valid = 1'h0, cof_paged = 1'h0, comp_c_match = 1'h0;
  logic head_adv = 1'h0, head_page = 1'h0, head_b16 = 1'h0;
  logic [3:0] trig_mode = 4'h0;
  logic [2:0] cof_ppage = 3'h0;
  logic [16:0] cof_addr = 17'h0, comp_c_addr, fifo_word, comp_c_load_addr;
  logic comp_c_page, module_enable_bit, armed, break_req, break_tag, fifo_store, fifo_page;
  logic comp_c_load, comp_c_load_page;
  logic [7:0] tag_cnt, force_cnt;
  logic [7:0] bc[3] = '{8'hF0, 8'hD0, 8'hE0};
  logic [1:0] bx[3] = '{2'h3, 2'h2, 2'h0};
  int num_errors = 0, check_count = 0, cycles = 0;

  dtc_top u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .secure,
    .soft_reset, .trig_begin, .trig_mode, .trig_hit, .fifo_full, .cof_valid, .cof_paged, .cof_ppage, .cof_addr,
    .comp_c_addr, .comp_c_page, .comp_c_match, .head_adv, .head_page, .head_b16, .module_enable_bit, .armed,
    .break_req, .break_tag, .fifo_store, .fifo_word, .fifo_page, .comp_c_load, .comp_c_load_addr,
    .comp_c_load_page);
  dtc_cpu_model u_cpu (.clk, .rst, .break_req, .break_tag, .comp_c_load, .comp_c_load_addr, .comp_c_load_page,
    .comp_c_addr, .comp_c_page, .tag_cnt, .force_cnt);

  always #2 clk = ~clk;

  task automatic results();
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Whole run is a bit over a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic e);
    apb(1'h0, a, 8'h00);
    check({errv, rdv}, {e, 24'h000000, x});
  endtask

  // Word expectation w is {page flag, word}; cw skips the word where it is not defined
  task automatic offer(input logic [16:0] a, input logic pg, input logic st, input logic [17:0] w, input logic cw);
    @(posedge clk);
    cof_valid <= 1'h1;
    cof_addr <= a;
    cof_paged <= pg;
    cof_ppage <= 3'h5;
    @(posedge clk);
    cof_valid <= 1'h0;
    @(posedge clk);
    check(fifo_store, st);
    if (st) check(fifo_page, w[17]);
    if (st && cw) check(fifo_word, w[16:0]);
  endtask

  task automatic strike(input logic [1:0] x);
    @(posedge clk);
    comp_c_match <= 1'h1;
    @(posedge clk);
    comp_c_match <= 1'h0;
    @(posedge clk);
    check({break_req, break_tag}, x);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rd(dtc_pkg::ADDR_CTRL, 8'hC0, 1'h0);
    rd(dtc_pkg::ADDR_FIFO_EXT, 8'h00, 1'h0);
    apb(1'h1, dtc_pkg::ADDR_FIFO_EXT, 8'hFF);
    rd(dtc_pkg::ADDR_FIFO_EXT, 8'h00, 1'h0);
    rd(8'h04, 8'h00, 1'h1);
    secure <= 1'h1;
    rd(dtc_pkg::ADDR_CTRL, 8'h40, 1'h0);
    apb(1'h1, dtc_pkg::ADDR_CTRL, 8'hC0);
    rd(dtc_pkg::ADDR_CTRL, 8'h40, 1'h0);
    check(module_enable_bit, 1'h0);
    secure <= 1'h0;
    apb(1'h1, dtc_pkg::ADDR_CTRL, 8'hC1);
    offer(17'h0ABCD, 1'h0, 1'h1, 18'h0ABCD, 1'h1);
    check({comp_c_load, comp_c_load_page, comp_c_load_addr}, {1'h1, 1'h0, 17'h0ABCD});
    offer(17'h0ABCD, 1'h0, 1'h0, 18'h0, 1'h0);
    check(comp_c_load, 1'h0);
    trig_mode <= dtc_pkg::TRG_EVONLY_B;
    offer(17'h0ABCD, 1'h1, 1'h1, 18'h0, 1'h0);
    trig_mode <= dtc_pkg::TRG_A_THEN_EVONLY_B;
    offer(17'h0ABCD, 1'h1, 1'h1, 18'h0, 1'h0);
    trig_mode <= 4'h0;
    apb(1'h1, dtc_pkg::ADDR_CTRL, 8'hC0);
    offer(17'h0ABCD, 1'h0, 1'h1, 18'h0ABCD, 1'h1);
    check(comp_c_load, 1'h0);
    offer(17'h1ABCD, 1'h1, 1'h1, 18'h36BCD, 1'h1);
    apb(1'h1, dtc_pkg::ADDR_CTRL, 8'h80);
    offer(17'h1ABCD, 1'h1, 1'h0, 18'h0, 1'h0);
    check(armed, 1'h0);
    foreach (bc[i]) begin
      apb(1'h1, dtc_pkg::ADDR_CTRL, bc[i]);
      strike(bx[i]);
    end
    apb(1'h1, dtc_pkg::ADDR_CTRL, 8'h80);
    trig_begin <= 1'h1;
    apb(1'h1, dtc_pkg::ADDR_CTRL, 8'hC0);
    offer(17'h00100, 1'h0, 1'h0, 18'h0, 1'h0);
    @(posedge clk) trig_hit <= 1'h1;
    @(posedge clk) trig_hit <= 1'h0;
    offer(17'h00100, 1'h0, 1'h1, 18'h00100, 1'h1);
    @(posedge clk) fifo_full <= 1'h1;
    @(posedge clk) fifo_full <= 1'h0;
    @(posedge clk) check(armed, 1'h0);
    trig_begin <= 1'h0;
    apb(1'h1, dtc_pkg::ADDR_CTRL, 8'hF1);
    @(posedge clk) trig_hit <= 1'h1;
    @(posedge clk) trig_hit <= 1'h0;
    head_adv <= 1'h1;
    head_page <= 1'h1;
    head_b16 <= 1'h1;
    @(posedge clk) head_adv <= 1'h0;
    rd(dtc_pkg::ADDR_FIFO_EXT, 8'h81, 1'h0);
    @(posedge clk) soft_reset <= 1'h1;
    @(posedge clk) soft_reset <= 1'h0;
    rd(dtc_pkg::ADDR_CTRL, 8'hA1, 1'h0);
    rd(dtc_pkg::ADDR_FIFO_EXT, 8'h81, 1'h0);
    // Run flag is gone now, so this reset is the ordinary kind
    @(posedge clk) soft_reset <= 1'h1;
    @(posedge clk) soft_reset <= 1'h0;
    rd(dtc_pkg::ADDR_CTRL, 8'hC0, 1'h0);
    rd(dtc_pkg::ADDR_FIFO_EXT, 8'h00, 1'h0);
    check({tag_cnt, force_cnt}, 16'h0201);
    results();
  end
endmodule
